// ===== epc_ctrl.sv
// Configuration-driven access control and reset handling of the emulator probe.
`timescale 1ns/10ps

module epc_ctrl #(
    parameter int CFG_W = 12  // Width of the stored configuration word.
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite slave.
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Nonvolatile store port.
    output logic                   nv_rd_req,
    input  wire logic              nv_rd_ack,
    input  wire logic [CFG_W-1:0]  nv_rd_data,
    input  wire logic              nv_blank,
    output logic                   nv_wr_req,
    output logic [CFG_W-1:0]       nv_wr_data,
    // ECU side.
    input  wire logic              power_save,
    input  wire logic              power_fail,
    input  wire logic              ecu_reset_line_n_i,
    output logic                   ecu_reset_line_n_o,
    output logic                   ecu_reset_line_n_oe,
    input  wire logic              mcu_reset_out_input_n,
    output logic [1:0]             boot_config_drive_pins_o,
    output logic                   boot_config_drive_pins_oe,
    output logic                   reset_config_drive_pin_n_o,
    output logic                   reset_config_drive_pin_n_oe,
    // Memory access gating.
    input  wire logic              bus_rd,
    input  wire logic              bus_wr,
    input  wire logic              bus_sel_data,
    input  wire logic              bus_sel_meas,
    input  wire logic              bus_sel_trig,
    output logic                   mem_rd_en,
    output logic                   mem_wr_en,
    output logic                   bus_respond,
    output logic                   mem_wr_protect,
    output logic                   meascal_en,
    output logic                   restore_req,
    output logic                   ram_ext_mode,
    output logic [1:0]             supv_level
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (CFG_W != epc_pkg::CFG_WIDTH) begin : g_bad_width
        $error("epc_ctrl: CFG_W must equal the configuration word width.");
    end

    // ------------------------------------------------------------------
    // Configuration loader
    // ------------------------------------------------------------------
    epc_pkg::epc_ld_state_t ld_q, ld_d;        // Loader state.
    logic [CFG_W-1:0]       cfg_q, cfg_d;      // Live configuration word.
    logic [3:0]             wait_q, wait_d;    // Least wait before data counts.
    logic                   loaded_q, loaded_d;// Configuration valid.
    logic                   nvw_q, nvw_d;      // Store write pulse.
    logic                   recov_q, recov_d;  // Recovery boot armed by software.
    logic                   swrst_q, swrst_d;  // Software-held ECU reset.

    // AXI bookkeeping.
    logic        aw_q, aw_d;                   // Write address captured.
    logic        w_q, w_d;                     // Write data captured.
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d;
    logic [3:0]  ws_q, ws_d;
    logic        bv_q, bv_d;
    logic [1:0]  br_q, br_d;
    logic        rv_q, rv_d;
    logic [31:0] rd_q, rd_d;
    logic [1:0]  rr_q, rr_d;

    // Decoded configuration fields.
    logic [2:0] mode;
    logic [2:0] boot;
    logic       pwr_inactive;
    logic       rstout_use;
    logic       ecu_in_reset;   // Monitored microcontroller reset state.
    assign mode         = cfg_q[epc_pkg::CFG_MODE_LSB +: 3];
    assign boot         = cfg_q[epc_pkg::CFG_BOOT_LSB +: 3];
    assign pwr_inactive = cfg_q[epc_pkg::CFG_PWRON_BIT];
    assign rstout_use   = cfg_q[epc_pkg::CFG_RSTOUT_BIT];

    // Check a proposed word: legal mode, and forced boot only with reset-out.
    function automatic logic cfg_ok(input logic [CFG_W-1:0] c);
        logic ok;
        ok = (c[epc_pkg::CFG_MODE_LSB +: 3] <= epc_pkg::MODE_DISABLED);
        ok = ok && (c[epc_pkg::CFG_BOOT_LSB +: 3] <= epc_pkg::BOOT_BY_ECU);
        ok = ok && (c[epc_pkg::CFG_SUPV_LSB +: 2] != 2'h3);
        ok = ok && ((c[epc_pkg::CFG_BOOT_LSB +: 3] == epc_pkg::BOOT_BY_ECU)
                    || c[epc_pkg::CFG_RSTOUT_BIT]);
        return ok;
    endfunction : cfg_ok

    // Next-state logic for loader, configuration and the AXI slave.
    // The loader holds the configuration at its default until the stored
    // word arrives, so the gating outputs never see a half-loaded word.
    always_comb begin
        logic [31:0] merged;
        merged   = {{(32-CFG_W){1'b0}}, cfg_q};
        ld_d     = ld_q;
        cfg_d    = cfg_q;
        wait_d   = wait_q;
        loaded_d = loaded_q;
        nvw_d    = 1'b0;
        recov_d  = recov_q;
        swrst_d  = swrst_q;
        aw_d = aw_q; w_d = w_q; awa_d = awa_q; wd_d = wd_q; ws_d = ws_q;
        bv_d = bv_q; br_d = br_q; rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
        unique case (ld_q)
            epc_pkg::EPC_LD_IDLE: begin
                wait_d = 4'h0;
                ld_d   = epc_pkg::EPC_LD_REQ;
            end
            epc_pkg::EPC_LD_REQ: begin
                if (wait_q < 4'(epc_pkg::LOAD_WAIT_CYC)) begin
                    wait_d = wait_q + 4'h1;
                end
                if (nv_rd_ack && wait_q >= 4'(epc_pkg::LOAD_WAIT_CYC)) begin
                    if (!nv_blank && cfg_ok(nv_rd_data)) begin
                        cfg_d = nv_rd_data;
                    end
                    loaded_d = 1'b1;
                    ld_d     = epc_pkg::EPC_LD_DONE;
                end
            end
            epc_pkg::EPC_LD_DONE: begin
                ld_d = epc_pkg::EPC_LD_DONE;
            end
        endcase
        // Write channel: take address and data in either order.
        if (s_axi_awvalid && !aw_q) begin
            aw_d  = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q) begin
            w_d  = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        if (aw_q && w_q && !bv_q) begin
            aw_d = 1'b0;
            w_d  = 1'b0;
            bv_d = 1'b1;
            br_d = epc_pkg::RESP_OKAY;
            if (awa_q == epc_pkg::REG_CFG_OFS) begin
                if (ws_q[0]) merged[7:0] = wd_q[7:0];
                if (ws_q[1]) merged[15:8] = wd_q[15:8];
                // Illegal words are refused so the store never holds one.
                if (loaded_q && cfg_ok(merged[CFG_W-1:0])) begin
                    cfg_d = merged[CFG_W-1:0];
                    nvw_d = 1'b1;
                end else begin
                    br_d = epc_pkg::RESP_SLVERR;
                end
            end else if (awa_q == epc_pkg::REG_CTRL_OFS) begin
                if (ws_q[0]) begin
                    recov_d = wd_q[0] && rstout_use;
                    swrst_d = wd_q[1];
                end
            end else begin
                br_d = epc_pkg::RESP_SLVERR;
            end
        end
        if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
        // Read channel.
        if (s_axi_arvalid && !rv_q) begin
            rv_d = 1'b1;
            rr_d = epc_pkg::RESP_OKAY;
            if (s_axi_araddr == epc_pkg::REG_CFG_OFS) begin
                rd_d = {{(32-CFG_W){1'b0}}, cfg_q};
            end else if (s_axi_araddr == epc_pkg::REG_STATUS_OFS) begin
                rd_d = {27'h0, ecu_in_reset, meascal_en, ram_ext_mode, loaded_q,
                        power_fail};
            end else if (s_axi_araddr == epc_pkg::REG_CTRL_OFS) begin
                rd_d = {30'h0, swrst_q, recov_q};
            end else begin
                rd_d = 32'h0000_0000;
                rr_d = epc_pkg::RESP_SLVERR;
            end
        end else if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // ECU-side decisions
    // ------------------------------------------------------------------
    // monitor MCU reset-out when reset-out is used, else the ECU reset line
    assign ecu_in_reset = rstout_use ? !mcu_reset_out_input_n : !ecu_reset_line_n_i;

    logic                 hold_rst_d, respond_d, rd_en_d, wr_en_d;
    logic                 wp_d, mc_d, rest_d, ram_d, bdrv_d, rcfg_d;
    logic                 hold_rst_q, respond_q, rd_en_q, wr_en_q;
    logic                 wp_q, mc_q, rest_q, ram_q, bdrv_q, rcfg_q;
    logic [1:0]           boot_d, boot_q, supv_d, supv_q;

    // Combinational access policy, registered below.
    always_comb begin
        logic ram_mode;
        logic data_ok;
        ram_mode = (mode == epc_pkg::MODE_RAM_INIT) || (mode == epc_pkg::MODE_RAM_NOINIT);
        // hold ECU reset during power save and init
        hold_rst_d = power_save || !loaded_q || swrst_q;
        respond_d  = loaded_q && (mode != epc_pkg::MODE_DISABLED);
        // active power-on state enables data memory
        // inactive power-on state blocks data memory
        data_ok    = !pwr_inactive;
        rd_en_d    = 1'b0;
        wr_en_d    = 1'b0;
        if (respond_d) begin
            if (bus_sel_data) begin
                rd_en_d = bus_rd && data_ok;
                wr_en_d = bus_wr && data_ok && cfg_q[epc_pkg::CFG_DWR_BIT];
            end else if (bus_sel_meas) begin
                rd_en_d = bus_rd && cfg_q[epc_pkg::CFG_MRD_BIT];
                wr_en_d = bus_wr;
            end else if (bus_sel_trig && !ram_mode) begin
                // trigger segment removed in RAM modes
                rd_en_d = bus_rd && cfg_q[epc_pkg::CFG_MRD_BIT];
                wr_en_d = bus_wr;
            end
        end
        wp_d   = ecu_in_reset;
        mc_d   = loaded_q && (mode == epc_pkg::MODE_EMU_INIT);
        // restore only in RAM-init or emulation-init
        rest_d = power_fail && loaded_q &&
                 ((mode == epc_pkg::MODE_RAM_INIT) || (mode == epc_pkg::MODE_EMU_INIT));
        ram_d  = loaded_q && ram_mode;
        // forced boot source drives boot pins
        // boot pins rely on ECU wiring
        bdrv_d = loaded_q && (recov_q || (boot != epc_pkg::BOOT_BY_ECU));
        boot_d = recov_q ? epc_pkg::BOOTCFG_EXTERNAL : boot[1:0];
        // Config pin goes low once reset is released while the boot pins are driven.
        rcfg_d = bdrv_d && !hold_rst_d;
        supv_d = cfg_q[epc_pkg::CFG_SUPV_LSB +: 2];
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Every output except the tied-low pin levels comes from a flop; reset values follow the defaults.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ld_q <= epc_pkg::EPC_LD_IDLE;
            cfg_q <= epc_pkg::CFG_RESET;
            wait_q <= 4'h0; loaded_q <= 1'b0; nvw_q <= 1'b0;
            recov_q <= 1'b0; swrst_q <= 1'b0;
            aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 8'h00; wd_q <= 32'h0; ws_q <= 4'h0;
            bv_q <= 1'b0; br_q <= 2'h0; rv_q <= 1'b0; rd_q <= 32'h0; rr_q <= 2'h0;
            hold_rst_q <= 1'b1; respond_q <= 1'b0; rd_en_q <= 1'b0; wr_en_q <= 1'b0;
            wp_q <= 1'b1; mc_q <= 1'b0; rest_q <= 1'b0; ram_q <= 1'b0;
            bdrv_q <= 1'b0; rcfg_q <= 1'b0; boot_q <= 2'h0; supv_q <= epc_pkg::SUPV_5V0;
        end else begin
            ld_q <= ld_d; cfg_q <= cfg_d; wait_q <= wait_d; loaded_q <= loaded_d;
            nvw_q <= nvw_d; recov_q <= recov_d; swrst_q <= swrst_d;
            aw_q <= aw_d; w_q <= w_d; awa_q <= awa_d; wd_q <= wd_d; ws_q <= ws_d;
            bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d; rd_q <= rd_d; rr_q <= rr_d;
            hold_rst_q <= hold_rst_d; respond_q <= respond_d;
            rd_en_q <= rd_en_d; wr_en_q <= wr_en_d; wp_q <= wp_d; mc_q <= mc_d;
            rest_q <= rest_d; ram_q <= ram_d; bdrv_q <= bdrv_d; rcfg_q <= rcfg_d;
            boot_q <= boot_d; supv_q <= supv_d;
        end
    end

    // ------------------------------------------------------------------
    // Output wiring
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_q;
    assign s_axi_wready  = !w_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = br_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rdata   = rd_q;
    assign s_axi_rresp   = rr_q;
    assign nv_rd_req     = (ld_q == epc_pkg::EPC_LD_REQ);
    assign nv_wr_req     = nvw_q;
    assign nv_wr_data    = cfg_q;
    // Open-drain reset: only ever pulled low.
    assign ecu_reset_line_n_o          = 1'b0;
    assign ecu_reset_line_n_oe         = hold_rst_q;
    assign boot_config_drive_pins_o    = boot_q;
    assign boot_config_drive_pins_oe   = bdrv_q;
    assign reset_config_drive_pin_n_o  = 1'b0;
    assign reset_config_drive_pin_n_oe = rcfg_q;
    assign mem_rd_en      = rd_en_q;
    assign mem_wr_en      = wr_en_q;
    assign bus_respond    = respond_q;
    assign mem_wr_protect = wp_q;
    assign meascal_en     = mc_q;
    assign restore_req    = rest_q;
    assign ram_ext_mode   = ram_q;
    assign supv_level     = supv_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_reset_hold_load: assert property (@(posedge aclk) disable iff (!aresetn)
        !loaded_q |=> ecu_reset_line_n_oe)
        else $error("ECU reset released before configuration load.");
    a_disabled_silent: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode == epc_pkg::MODE_DISABLED) |=> !bus_respond && !mem_rd_en && !mem_wr_en)
        else $error("Disabled probe answered a bus access.");
    a_meascal_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        meascal_en |-> $past(mode) == epc_pkg::MODE_EMU_INIT)
        else $error("Measurement enabled outside emulation-init mode.");
    a_data_inactive: assert property (@(posedge aclk) disable iff (!aresetn)
        (pwr_inactive && bus_sel_data) |=> !mem_rd_en && !mem_wr_en)
        else $error("Data memory answered while power-on inactive.");
    a_data_wprot: assert property (@(posedge aclk) disable iff (!aresetn)
        (bus_sel_data && bus_wr && !cfg_q[epc_pkg::CFG_DWR_BIT]) |=> !mem_wr_en)
        else $error("Data memory written while write protected.");
    a_meas_rprot: assert property (@(posedge aclk) disable iff (!aresetn)
        (bus_sel_meas && bus_rd && !cfg_q[epc_pkg::CFG_MRD_BIT]) |=> !mem_rd_en)
        else $error("Measurement memory read while read protected.");
    a_trig_removed: assert property (@(posedge aclk) disable iff (!aresetn)
        ((mode == epc_pkg::MODE_RAM_INIT || mode == epc_pkg::MODE_RAM_NOINIT)
         && bus_sel_trig && !bus_sel_data && !bus_sel_meas) |=> !mem_rd_en && !mem_wr_en)
        else $error("Trigger segment answered in RAM extension mode.");
    a_boot_needs_ro: assert property (@(posedge aclk) disable iff (!aresetn)
        (boot != epc_pkg::BOOT_BY_ECU) |-> rstout_use)
        else $error("Forced boot mode without reset-out monitoring.");
    a_wp_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 (mem_wr_protect == $past(ecu_in_reset)))
        else $error("Write protect does not follow the monitored reset.");
    a_noinit_restore: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode == epc_pkg::MODE_EMU_NOINIT || mode == epc_pkg::MODE_RAM_NOINIT)
        |=> !restore_req)
        else $error("Restore requested in a no-restore mode.");

endmodule : epc_ctrl

// ===== epc_pkg.sv
// Package with configuration encodings, register map and timing constants of the probe control.
package epc_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses on the AXI4-Lite slave)
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CFG_OFS    = 8'h00;
    localparam logic [7:0] REG_STATUS_OFS = 8'h04;
    localparam logic [7:0] REG_CTRL_OFS   = 8'h08;

    // ------------------------------------------------------------------
    // Configuration word field positions
    // ------------------------------------------------------------------
    localparam int CFG_MODE_LSB   = 0;   // Usage mode, 3 bits.
    localparam int CFG_PWRON_BIT  = 3;   // 1 = power-on state inactive.
    localparam int CFG_RSTOUT_BIT = 4;   // 1 = reset-out input monitored.
    localparam int CFG_BOOT_LSB   = 5;   // Boot mode, 3 bits.
    localparam int CFG_SUPV_LSB   = 8;   // Supply supervision level, 2 bits.
    localparam int CFG_MRD_BIT    = 10;  // 1 = measurement memory read enabled.
    localparam int CFG_DWR_BIT    = 11;  // 1 = data memory write enabled.
    localparam int CFG_WIDTH      = 12;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [2:0] MODE_EMU_INIT   = 3'h0;
    localparam logic [2:0] MODE_EMU_NOINIT = 3'h1;
    localparam logic [2:0] MODE_RAM_NOINIT = 3'h2;
    localparam logic [2:0] MODE_RAM_INIT   = 3'h3;
    localparam logic [2:0] MODE_DISABLED   = 3'h4;

    localparam logic [2:0] BOOT_INTERNAL   = 3'h0;
    localparam logic [2:0] BOOT_SERIAL     = 3'h1;
    localparam logic [2:0] BOOT_EXT_SINGLE = 3'h2;
    localparam logic [2:0] BOOT_EXT_MULTI  = 3'h3;
    localparam logic [2:0] BOOT_BY_ECU     = 3'h4;

    localparam logic [1:0] SUPV_2V5 = 2'h0;
    localparam logic [1:0] SUPV_3V3 = 2'h1;
    localparam logic [1:0] SUPV_5V0 = 2'h2;

    // Boot-config drive pattern for external single master boot.
    localparam logic [1:0] BOOTCFG_EXTERNAL = 2'h1;

    // Default configuration word (also the value used when the stored set is blank).
    // Emulation-init, power-on active, reset-out No, boot by ECU, 5.0 V,
    // measurement memory read protected, data memory write protected.
    localparam logic [11:0] CFG_RESET = 12'h280;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_NS        = 4;
    localparam int LOAD_WAIT_NS  = 40;   // Least wait for a stored word to arrive.
    localparam int LOAD_WAIT_CYC = (LOAD_WAIT_NS + CLK_NS - 1) / CLK_NS;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Loader states.
    typedef enum logic [1:0] {
        EPC_LD_IDLE,
        EPC_LD_REQ,
        EPC_LD_DONE
    } epc_ld_state_t;

endpackage : epc_pkg

// ===== epc_nv_model.sv
// Nonvolatile store model that answers the configuration loader.
`timescale 1ns/10ps
module epc_nv_model #(
    parameter int          DLY  = 14,
    parameter logic [11:0] WORD = 12'h180
) (
    input  wire logic        aclk,
    input  wire logic        nv_rd_req,
    output logic             nv_rd_ack,
    output logic [11:0]      nv_rd_data,
    output logic             nv_blank
);
    int cnt;  // Cycles since the request rose; cleared while no request stands.
    // stored word survives
    // A slow answer; the data lines show the inverse outside the acknowledge.
    always_ff @(posedge aclk) begin
        cnt <= nv_rd_req ? cnt + 1 : 0;
    end
    assign nv_rd_ack  = nv_rd_req && cnt >= DLY;
    assign nv_rd_data = nv_rd_ack ? WORD : ~WORD;
    assign nv_blank   = 1'b0;
endmodule : epc_nv_model

// ===== emulator_probe_config_access_control_tb.sv
// Self-checking bench of the probe control block.
`timescale 1ns/10ps
module emulator_probe_config_access_control_tb;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic b_rd = 0, b_wr = 0, s_d = 0, s_m = 0, awrdy, wrdy, bvalid, arrdy, rvalid;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdata, d;
    logic [1:0] bresp, rresp, supv, r;
    logic [11:0] nvd;
    logic req, ack, blank, rst_oe, m_rd, m_wr, resp, wprot, mcal;
    int n_errors = 0, checks_done = 0;
    initial forever #2 aclk = ~aclk;
    epc_nv_model i_nv (.aclk(aclk), .nv_rd_req(req), .nv_rd_ack(ack), .nv_rd_data(nvd),
        .nv_blank(blank));
    // The reset line has a pull-up and is pulled low while the enable is high.
    // ECU wiring: boot pins left open, boot is selected by the ECU here.
    epc_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arrdy),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .nv_rd_req(req), .nv_rd_ack(ack), .nv_rd_data(nvd), .nv_blank(blank), .nv_wr_req(),
        .nv_wr_data(), .power_save(1'b0), .power_fail(1'b0), .ecu_reset_line_n_i(!rst_oe),
        .ecu_reset_line_n_o(), .ecu_reset_line_n_oe(rst_oe), .mcu_reset_out_input_n(1'b1),
        .boot_config_drive_pins_o(), .boot_config_drive_pins_oe(),
        .reset_config_drive_pin_n_o(), .reset_config_drive_pin_n_oe(), .bus_rd(b_rd),
        .bus_wr(b_wr), .bus_sel_data(s_d), .bus_sel_meas(s_m), .bus_sel_trig(1'b0),
        .mem_rd_en(m_rd), .mem_wr_en(m_wr), .bus_respond(resp), .mem_wr_protect(wprot),
        .meascal_en(mcal), .restore_req(), .ram_ext_mode(), .supv_level(supv));
    // Compares one value and counts the outcome.
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, s, e);
        end
    endtask : chk
    // Write: address and data offered together, each dropped once taken.
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awa <= a; wd <= v; awv <= 1; wv <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awrdy) awv <= 0;
            if (wrdy) wv <= 0;
        end while (!bvalid);
        r = bresp;
        bready <= 0;
    endtask : wr
    // Read: the answer is taken at the edge where rvalid is seen.
    task rd(input logic [7:0] a);
        @(posedge aclk);
        ara <= a; arv <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arrdy) arv <= 0;
        end while (!rvalid);
        r = rresp; d = rdata;
        rready <= 0;
    endtask : rd
    // One bus access; the enables answer one cycle later.
    task acc(input logic rd_, input logic wr_, input logic ds, input logic [1:0] e);
        @(posedge aclk);
        b_rd <= rd_; b_wr <= wr_; s_d <= ds; s_m <= !ds;
        @(posedge aclk);
        #1 chk({m_rd, m_wr}, e);
    endtask : acc
    task tally_and_finish;
        $display("mismatches %0d comparisons %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    // A hang is cut after far more than the sequence needs.
    initial begin
        #40000 n_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        rd(epc_pkg::REG_CFG_OFS);
        chk(d, 32'h280);
        chk(supv, 2);
        chk(rst_oe, 1);
        for (int i = 0; i < 60 && rst_oe !== 0; i++) @(posedge aclk);
        rd(epc_pkg::REG_CFG_OFS);
        chk(d, 32'h180);
        chk({supv, wprot, mcal}, 4'h5);
        acc(1, 0, 0, 2'b00);
        acc(0, 1, 0, 2'b01);
        acc(1, 0, 1, 2'b10);
        acc(0, 1, 1, 2'b00);
        wr(epc_pkg::REG_CFG_OFS, 32'h140);
        chk(r, epc_pkg::RESP_SLVERR);
        // the project set differs from the stored one, so reprogram it.
        if (d !== 32'h184) wr(epc_pkg::REG_CFG_OFS, 32'h184);
        chk(r, epc_pkg::RESP_OKAY);
        acc(1, 0, 1, 2'b00);
        chk({resp, mcal}, 0);
        rd(8'h0C);
        chk(r, epc_pkg::RESP_SLVERR);
        chk(d, 32'h0);
        tally_and_finish;
    end
endmodule : emulator_probe_config_access_control_tb
